// >>> rtl/pllr_device.sv
// device end: scan chain, update logic and five programmable output dividers
//
// Rules of the link, kept by this block and its controller
// R1: feedback, prescale, outputs, pump, filter reconfigurable live
// R2: serial bits clocked in, clock at most 100 MHz
// R3: high gate shifts; low gate leaves chain alone
// R4: gate rises one clock before first bit
// R5: first bit captured second edge after gate
// R6: gate lowered after 144 bits shifted
// R7: strobe copies chain into active settings
// R8: done high during update, falls when done
// R9: each divider switches at its own boundary
// R10: loop changes need loop reset pulse
// R11: sequence repeats without limit
// R12: chain contents appear on serial output
// R13: frequency update keeps divider phase; a following loop reset clears the divider counters
// R14: eight-bit high and low counts set division
// R15: bypass bit gives divide by one
// R16: select low: fall on rising edge
// R17: select high: fall on falling edge
// R18: chain is 144 bits, fixed slice sizes
// R19: first bit divider four low lsb
// R20: bypass ignores all other count bits
// R21: no gate, no strobe: nothing changes
`timescale 1ns/1ns
module pllr_device
    import pllr_pkg::*;
(
    input  wire logic                 clock_i,            // oscillator and shift clock
    input  wire logic                 rst_n_i,            // synchronous reset
    pllr_link_if.device               link,               // chain pins
    output logic [NUM_OUT-1:0]        divided_clock_o,    // output_dividers clocks
    output logic [DIV_BITS-1:0]       feedback_setting_o, // active feedback divider
    output logic [DIV_BITS-1:0]       prescale_setting_o, // active prescale divider
    output logic [LOOP_BITS-1:0]      pump_setting_o,     // active pump current
    output logic [LOOP_BITS-1:0]      filter_setting_o,   // active loop filter
    output logic                      update_busy_o       // dividers still pending
);
    logic [CHAIN_BITS-1:0] chain;      // scan chain, bit 0 oldest
    logic                  gate_d;     // gate seen on previous edge
    logic                  strobe_d;   // strobe seen on previous edge
    logic                  done_q;     // done pulse register
    logic                  shift_en;   // shift on this edge
    logic                  apply;      // strobe rising edge
    logic [NUM_OUT-1:0]    pend_vec;   // dividers waiting to switch
    logic [DIV_BITS-1:0]   fb_q;       // active feedback
    logic [DIV_BITS-1:0]   pre_q;      // active prescale
    logic [LOOP_BITS-1:0]  pump_q;     // active pump
    logic [LOOP_BITS-1:0]  filt_q;     // active filter

    // gate must have been high on the edge before, so the first edge
    // after it rises only arms and the second one shifts
    assign shift_en = link.shift_clock_gate & gate_d;       // [R5]
    assign apply    = link.apply_config_strobe & ~strobe_d; // [R7]

    // edge history of gate and strobe
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            gate_d   <= 1'b0;
            strobe_d <= 1'b0;
        end
        else
        begin
            gate_d   <= link.shift_clock_gate;
            strobe_d <= link.apply_config_strobe;
        end
    end

    // scan chain: new bit enters at the top, so after 144 shifts the
    // first bit sits at bit 0 and the last at bit 143
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            chain <= CHAIN_RESET;
        else if (shift_en)                                     // [R3] [R2]
            chain <= {link.serial_config_in, chain[CHAIN_BITS-1:1]}; // [R18] [R19]
        // otherwise hold, running clock or not [R21]
    end

    // oldest bit is what the next shift pushes out
    assign link.serial_config_out = chain[0]; // [R12]

    // loop settings switch at once; they only take proper effect after
    // the controller pulses the loop reset
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            fb_q   <= DIV_RESET;
            pre_q  <= DIV_RESET;
            pump_q <= LOOP_RESET;
            filt_q <= LOOP_RESET;
        end
        else if (apply)                                        // [R1] [R21]
        begin
            fb_q   <= chain[FB_BASE +: DIV_BITS];
            pre_q  <= chain[PRE_BASE +: DIV_BITS];
            pump_q <= chain[PUMP_BASE +: LOOP_BITS];
            filt_q <= chain[FILT_BASE +: LOOP_BITS];
        end
    end

    // done rises after the strobe and falls once every divider switched;
    // a repeat strobe re-raises it, so sequences can follow freely
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            done_q <= 1'b0;
        else if (apply)                                        // [R8] [R11]
            done_q <= 1'b1;
        else if (pend_vec == '0)
            done_q <= 1'b0;                                    // [R8]
    end

    // one output divider per slice, output 4 at the chain bottom
    for (genvar gi = 0; gi < NUM_OUT; gi++)
    begin : g_div
        localparam int BASE = OUT_LAST_BASE + (NUM_OUT - 1 - gi) * DIV_BITS;

        logic [DIV_BITS-1:0] staged;    // snapshot taken at the strobe
        logic [DIV_BITS-1:0] active;    // setting in use
        logic                pending;   // snapshot not yet adopted
        logic [8:0]          cnt;       // position in the period
        logic [8:0]          total;     // division factor
        logic [8:0]          cnt_inc;   // cnt plus one
        logic [8:0]          high_w;    // high count widened
        logic                boundary;  // last cycle of the period
        logic                next_out;  // level after the next rising edge
        logic                out_q;     // rising-edge output level
        logic                cut_n;     // falling-edge early drop
        logic                bypass;
        logic                odd_sel;

        assign bypass   = active[BYP_POS];
        assign odd_sel  = active[ODD_POS];
        assign high_w   = {1'b0, active[HIGH_POS +: CNT_BITS]};
        // division is high count plus low count [R14]
        assign total    = high_w + {1'b0, active[LOW_POS +: CNT_BITS]}; // [R14]
        assign cnt_inc  = cnt + 9'h001;
        // bypassed divider is at a boundary every cycle [R20]
        assign boundary = bypass | (cnt_inc >= total);
        assign next_out = boundary ? (high_w != 9'h000) : (cnt_inc < high_w);

        // snapshot on the strobe; a new strobe wins over adoption
        always_ff @(posedge clock_i)
        begin
            if (!rst_n_i)
            begin
                staged  <= DIV_RESET;
                pending <= 1'b0;
            end
            else if (apply)
            begin
                staged  <= chain[BASE +: DIV_BITS];
                pending <= 1'b1;
            end
            else if (pending && boundary)
                pending <= 1'b0;                               // [R9]
        end

        // adopt only at this divider's own period boundary, so outputs
        // switch at different moments and no runt pulse appears
        always_ff @(posedge clock_i)
        begin
            if (!rst_n_i)
                active <= DIV_RESET;
            else if (pending && boundary)
                active <= staged;                              // [R9] [R1]
        end

        // period counter; a new setting does not restart it, but the loop reset clears it,
        // so the divider keeps its phase across an update only when no loop reset follows
        always_ff @(posedge clock_i)
        begin
            if (!rst_n_i || link.pll_async_reset)
            begin
                cnt   <= 9'h000;
                out_q <= 1'b0;
            end
            else
            begin
                cnt   <= boundary ? 9'h000 : cnt_inc;          // [R13]
                out_q <= next_out;                             // [R16]
            end
        end

        // with odd select, drop half a cycle early on the falling edge
        always_ff @(negedge clock_i)
        begin
            if (!rst_n_i)
                cut_n <= 1'b0;
            else
                cut_n <= odd_sel & out_q & ~next_out;          // [R17]
        end

        // bypass passes the oscillator straight through [R15]
        assign divided_clock_o[gi] = bypass ? clock_i : (out_q & ~cut_n); // [R15] [R20]
        assign pend_vec[gi]        = pending;
    end

    assign link.reconfig_done_pulse = done_q;
    assign feedback_setting_o       = fb_q;
    assign prescale_setting_o       = pre_q;
    assign pump_setting_o           = pump_q;
    assign filter_setting_o         = filt_q;
    assign update_busy_o            = pend_vec != '0;
endmodule : pllr_device

// >>> rtl/pllr_pkg.sv
// shared constants for the loop reconfiguration scan chain and its controller
package pllr_pkg;
    // clocking
    localparam int CLOCK_MHZ      = 100;           // system and shift clock rate
    localparam int SHIFT_MAX_MHZ  = 100;           // highest allowed shift clock rate
    // chain geometry
    localparam int CHAIN_BITS     = 144;           // whole scan chain
    localparam int DIV_BITS       = 18;            // one divider slice
    localparam int CNT_BITS       = 8;             // high or low count width
    localparam int LOOP_BITS      = 9;             // pump or filter slice
    localparam int NUM_OUT        = 5;             // output dividers
    // slice positions, first bit shifted in lands at bit 0
    localparam int OUT_LAST_BASE  = 0;             // output divider 4 (first in)
    localparam int FB_BASE        = 90;            // feedback divider
    localparam int PRE_BASE       = 108;           // prescale divider
    localparam int PUMP_BASE      = 126;           // pump current setting
    localparam int FILT_BASE      = 135;           // loop filter r and c settings
    localparam int LOOP_SPAN      = 54;            // feedback..filter, needs loop reset
    // field positions inside a divider slice
    localparam int LOW_POS        = 0;             // low count lsb
    localparam int ODD_POS        = 8;             // odd_half_cycle_select
    localparam int HIGH_POS       = 9;             // high count lsb
    localparam int BYP_POS        = 17;            // divider_bypass_bit
    // reset values
    localparam logic [DIV_BITS-1:0]   DIV_RESET   = 18'h20000; // bypassed
    localparam logic [LOOP_BITS-1:0]  LOOP_RESET  = 9'h000;
    localparam logic [CHAIN_BITS-1:0] CHAIN_RESET = 144'h0;
    // controller counts
    localparam logic [7:0] LAST_SHIFT = 8'h8f;     // index of bit 143
endpackage : pllr_pkg

// >>> rtl/pllr_link_if.sv
// scan chain link between the reconfiguration controller and the loop
`timescale 1ns/1ns
interface pllr_link_if;
    logic shift_clock_gate;      // enables shifting
    logic serial_config_in;      // serial data into chain
    logic apply_config_strobe;   // copy chain to active settings
    logic reconfig_done_pulse;   // high while update in progress
    logic serial_config_out;     // chain contents out
    logic pll_async_reset;       // loop reset after loop changes

    modport device (
        input  shift_clock_gate,
        input  serial_config_in,
        input  apply_config_strobe,
        input  pll_async_reset,
        output reconfig_done_pulse,
        output serial_config_out
    );
    modport ctrl (
        output shift_clock_gate,
        output serial_config_in,
        output apply_config_strobe,
        output pll_async_reset,
        input  reconfig_done_pulse,
        input  serial_config_out
    );
endinterface : pllr_link_if

// >>> rtl/pllr_controller.sv
// controller end: shifts an image into the chain, applies it, resets loop if needed
`timescale 1ns/1ns
module pllr_controller
    import pllr_pkg::*;
(
    input  wire logic                  clock_i,       // shift clock, at most 100 MHz
    input  wire logic                  rst_n_i,       // synchronous reset
    pllr_link_if.ctrl                  link,          // chain pins
    input  wire logic                  start_i,       // begin one reconfiguration
    input  wire logic [CHAIN_BITS-1:0] image_i,       // new chain image
    output logic                       busy_o,        // sequence running
    output logic                       done_o,        // one-cycle completion pulse
    output logic [CHAIN_BITS-1:0]      readback_o     // previous chain contents
);
    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_ARM    = 7'h02,
        ST_SHIFT  = 7'h04,
        ST_UPDATE = 7'h08,
        ST_WAIT   = 7'h10,
        ST_RESET  = 7'h20,
        ST_FINISH = 7'h40
    } pllr_ctl_e;

    pllr_ctl_e             state;      // sequence state
    logic [CHAIN_BITS-1:0] image;      // latched image
    logic [LOOP_SPAN-1:0]  last_loop;  // loop settings last applied
    logic [7:0]            idx;        // bit being shifted
    logic                  seen_done;  // done pulse has risen
    logic                  gate;       // registered gate pin
    logic                  data;       // registered data pin
    logic                  strobe;     // registered apply pin
    logic                  loop_rst;   // registered loop reset pin
    logic                  done_q;     // completion pulse
    logic [CHAIN_BITS-1:0] readback;   // captured old contents
    logic                  needs_reset;

    // loop reset only when feedback, prescale, pump or filter moved
    assign needs_reset = image[FB_BASE +: LOOP_SPAN] != last_loop; // [R10]

    // sequence; shifting, applying and waiting repeat freely [R11]
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            state     <= ST_IDLE;
            idx       <= 8'h00;
            seen_done <= 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:   if (start_i) state <= ST_ARM;
                // gate goes up a full cycle ahead of the first bit [R4]
                ST_ARM:
                begin
                    idx   <= 8'h00;
                    state <= ST_SHIFT;
                end
                ST_SHIFT:
                begin
                    idx <= idx + 8'h01;
                    if (idx == LAST_SHIFT) state <= ST_UPDATE; // [R6]
                end
                ST_UPDATE:
                begin
                    seen_done <= 1'b0;
                    state     <= ST_WAIT;
                end
                // falling edge of the done pulse ends the update [R8]
                ST_WAIT:
                begin
                    if (link.reconfig_done_pulse) seen_done <= 1'b1;
                    else if (seen_done) state <= needs_reset ? ST_RESET : ST_FINISH;
                end
                ST_RESET:  state <= ST_FINISH;
                ST_FINISH: state <= ST_IDLE;
                default:   state <= ST_IDLE;
            endcase
        end
    end

    // image and memory of loop settings
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            image     <= CHAIN_RESET;
            // same as the device's own reset settings (filter, pump, prescale, feedback),
            // so a first image that moves them still earns its loop reset
            last_loop <= {LOOP_RESET, LOOP_RESET, DIV_RESET, DIV_RESET}; // [R10]
        end
        else if (state == ST_IDLE && start_i)
            image <= image_i;
        else if (state == ST_FINISH)
            last_loop <= image[FB_BASE +: LOOP_SPAN];
    end

    // pin drivers, all registered
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            gate     <= 1'b0;
            data     <= 1'b0;
            strobe   <= 1'b0;
            loop_rst <= 1'b0;
        end
        else
        begin
            gate     <= (state == ST_IDLE && start_i) || state == ST_ARM ||
                        (state == ST_SHIFT && idx != LAST_SHIFT);  // [R3] [R6]
            // bit 0 first, i.e. lsb of output divider 4 low count [R19]
            if (state == ST_IDLE && start_i) data <= image_i[0];
            else if (state == ST_SHIFT && idx != LAST_SHIFT)
                data <= image[idx + 8'h01];                        // [R2]
            strobe   <= state == ST_SHIFT && idx == LAST_SHIFT;    // [R7]
            loop_rst <= state == ST_WAIT && seen_done &&
                        !link.reconfig_done_pulse && needs_reset;  // [R10]
        end
    end

    // old contents come out one per shift edge
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i) readback <= CHAIN_RESET;
        else if (state == ST_SHIFT)
            readback <= {link.serial_config_out, readback[CHAIN_BITS-1:1]}; // [R12]
    end

    // completion pulse
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i) done_q <= 1'b0;
        else          done_q <= state == ST_FINISH;
    end

    assign link.shift_clock_gate    = gate;
    assign link.serial_config_in    = data;
    assign link.apply_config_strobe = strobe;
    assign link.pll_async_reset     = loop_rst;
    assign busy_o                   = state != ST_IDLE;
    assign done_o                   = done_q;
    assign readback_o               = readback;
endmodule : pllr_controller

// >>> sim/pllr_link_sva.sv
// checker for the chain link between controller and device
`timescale 1ns/1ns
module pllr_link_sva
(
    input  wire logic clock_i,             // shared clock
    input  wire logic rst_n_i,             // sync reset, active low
    input  wire logic shift_clock_gate,    // shift enable
    input  wire logic serial_config_in,    // serial data in
    input  wire logic apply_config_strobe, // update strobe
    input  wire logic reconfig_done_pulse, // update in progress
    input  wire logic serial_config_out,   // chain bit 0
    input  wire logic pll_async_reset      // loop reset pulse
);
    logic [7:0] gate_run; // samples in current gate-high run

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // run length of the gate, cleared whenever it drops
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || !shift_clock_gate)
            gate_run <= 8'h00;
        else
            gate_run <= gate_run + 8'h01;
    end

    sequence s_apply;     // strobe rise
        !apply_config_strobe ##1 apply_config_strobe;
    endsequence
    sequence s_gate_drop; // end of a shift burst
        shift_clock_gate ##1 !shift_clock_gate;
    endsequence

    // one arming sample plus 144 shifts
    chk_gate_run_length: assert property (s_gate_drop |-> gate_run == 8'h91)
        else $error("gate high run is not 145 cycles");
    chk_strobe_after_gate: assert property (s_gate_drop |-> apply_config_strobe)
        else $error("no strobe at end of burst");
    chk_strobe_one_cycle: assert property (s_apply |=> !apply_config_strobe)
        else $error("strobe wider than one cycle");
    chk_done_after_apply: assert property (s_apply |-> ##2 reconfig_done_pulse)
        else $error("done not raised after strobe");
    chk_done_min_high: assert property ($rose(reconfig_done_pulse) |=> reconfig_done_pulse)
        else $error("done pulse too short");
    chk_done_bounded: assert property ($rose(reconfig_done_pulse)
        |-> ##[1:1000] !reconfig_done_pulse)
        else $error("done never fell");
    chk_chain_frozen: assert property ((!shift_clock_gate && !$past(shift_clock_gate))
        |-> $stable(serial_config_out))
        else $error("chain moved with gate low");
    chk_first_bit_out: assert property (s_gate_drop
        |-> serial_config_out == $past(serial_config_in, 144))
        else $error("first bit not at chain end");
    chk_loop_reset_quiet: assert property (pll_async_reset
        |-> (!shift_clock_gate && !reconfig_done_pulse) ##1 !pll_async_reset)
        else $error("loop reset out of place");
endmodule : pllr_link_sva

// >>> sim/pll_scan_chain_reconfig_bench.sv
// self-checking bench: controller and device joined over the chain link
`timescale 1ns/1ns
`define CHK(g, e) \
    begin \
        checks_done++; \
        if ((g) !== (e)) \
        begin \
            mismatches++; \
            $display("[ERR] t=%0t got %h exp %h", $time, g, e); \
        end \
    end
module pll_scan_chain_reconfig_bench
    import pllr_pkg::*;
;
    logic                  clock_i;    // 100 MHz
    logic                  rst_n_i;    // sync reset
    logic                  start_i;    // run request
    logic [CHAIN_BITS-1:0] image_i;    // image to load
    logic                  busy_o;     // controller busy
    logic                  done_o;     // completion pulse
    logic [CHAIN_BITS-1:0] readback_o; // old chain contents
    logic [NUM_OUT-1:0]    div_clk;    // divider outputs
    logic [DIV_BITS-1:0]   fb_set;     // active feedback
    logic [DIV_BITS-1:0]   pre_set;    // active prescale
    logic [LOOP_BITS-1:0]  pump_set;   // active pump
    logic [LOOP_BITS-1:0]  filt_set;   // active filter
    logic                  upd_busy;   // dividers pending
    logic [CHAIN_BITS-1:0] prev_img;   // last image applied
    logic [CHAIN_BITS-1:0] img;        // image under test
    logic [LOOP_SPAN-1:0]  prev_loop;  // loop slice last applied
    int                    exp_resets; // loop resets expected so far
    int                    loop_resets = 0; // loop resets seen so far
    logic [159:0]          raw;        // random words
    int                    mismatches;
    int                    checks_done;
    int                    cycles;     // timeout counter
    integer                seed;       // fixed random seed

    pllr_link_if pllr_link_if_i ();
    pllr_device pllr_device_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .link(pllr_link_if_i),
        .divided_clock_o(div_clk), .feedback_setting_o(fb_set), .prescale_setting_o(pre_set),
        .pump_setting_o(pump_set), .filter_setting_o(filt_set), .update_busy_o(upd_busy));
    pllr_controller pllr_controller_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .link(pllr_link_if_i), .start_i(start_i), .image_i(image_i), .busy_o(busy_o),
        .done_o(done_o), .readback_o(readback_o));
    pllr_link_sva pllr_link_sva_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .shift_clock_gate(pllr_link_if_i.shift_clock_gate),
        .serial_config_in(pllr_link_if_i.serial_config_in),
        .apply_config_strobe(pllr_link_if_i.apply_config_strobe),
        .reconfig_done_pulse(pllr_link_if_i.reconfig_done_pulse),
        .serial_config_out(pllr_link_if_i.serial_config_out),
        .pll_async_reset(pllr_link_if_i.pll_async_reset));

    // free-running clock
    initial clock_i = 1'b0;
    always #5 clock_i = ~clock_i;

    // hang guard, well above seven runs of at most ~700 cycles
    always @(posedge clock_i)
    begin
        cycles++;
        // count each loop reset pulse as it is sampled
        if (pllr_link_if_i.pll_async_reset === 1'b1)
            loop_resets++;
        if (cycles == 20000)
        begin
            mismatches++;
            summarize();
        end
    end

    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    // legal divider slice: period 2..6 divides the 60-cycle window
    function automatic logic [DIV_BITS-1:0] rand_div();
        int p;
        int h;
        int l;
        logic [DIV_BITS-1:0] s;
        p = 2 + ($unsigned($random(seed)) % 5);
        h = 1 + ($unsigned($random(seed)) % (p - 1));
        l = p - h;
        s = '0;
        s[HIGH_POS +: CNT_BITS] = h[7:0];
        s[LOW_POS +: CNT_BITS] = l[7:0];
        s[ODD_POS] = $random(seed) & 1;
        s[BYP_POS] = ($unsigned($random(seed)) % 4) == 0;
        return s;
    endfunction : rand_div

    // high samples in the late half of 60 cycles
    function automatic int exp_high(input logic [DIV_BITS-1:0] s);
        int h;
        int p;
        h = s[HIGH_POS +: CNT_BITS];
        p = h + s[LOW_POS +: CNT_BITS];
        if (s[BYP_POS] || p == 0)
            return 0; // bypass follows clock, low late in the cycle
        return (60 / p) * (h - s[ODD_POS]);
    endfunction : exp_high

    // one whole reconfiguration, a refused start, then the checks
    task automatic run(input logic [CHAIN_BITS-1:0] im, input int tn);
        int n;
        int i;
        int hi [NUM_OUT];
        @(posedge clock_i);
        start_i <= 1'b1;
        image_i <= im;
        @(posedge clock_i);
        start_i <= 1'b0;
        repeat (10) @(posedge clock_i);
        start_i <= 1'b1; // ignored, controller busy
        @(posedge clock_i);
        start_i <= 1'b0;
        #1;
        `CHK(busy_o, 1'b1)
        n = 0;
        while (done_o !== 1'b1 && n < 3000)
        begin
            @(posedge clock_i);
            #1;
            n++;
        end
        `CHK(done_o, 1'b1)
        `CHK(readback_o, prev_img)
        // loop reset only when feedback, prescale, pump or filter moved
        if (im[CHAIN_BITS-1:FB_BASE] !== prev_loop)
            exp_resets++;
        `CHK(loop_resets, exp_resets)
        for (i = 0; i < NUM_OUT; i++)
            hi[i] = 0;
        repeat (4) @(posedge clock_i);
        repeat (60)
        begin
            @(posedge clock_i);
            #7;
            for (i = 0; i < NUM_OUT; i++)
                hi[i] += (div_clk[i] === 1'b1);
        end
        for (i = 0; i < NUM_OUT; i++)
            `CHK(hi[i], exp_high(im[(4-i)*DIV_BITS +: DIV_BITS]))
        `CHK(busy_o, 1'b0)
        `CHK(upd_busy, 1'b0)
        `CHK(fb_set, im[FB_BASE +: DIV_BITS])
        `CHK(pre_set, im[PRE_BASE +: DIV_BITS])
        `CHK({filt_set, pump_set}, im[PUMP_BASE +: 2 * LOOP_BITS])
        prev_img = im;
        prev_loop = im[CHAIN_BITS-1:FB_BASE];
        $display("test %0d finished", tn);
    endtask : run

    // main sequence: reset, corner images, random images
    initial
    begin
        seed = 32'hc68e45e6;
        mismatches = 0;
        checks_done = 0;
        cycles = 0;
        rst_n_i = 1'b0;
        start_i = 1'b0;
        image_i = '0;
        prev_img = '0;
        // device resets its loop settings to these, not to zero
        prev_loop = {LOOP_RESET, LOOP_RESET, DIV_RESET, DIV_RESET};
        exp_resets = 0;
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        #2;
        `CHK(div_clk, 5'h1f)
        #5;
        `CHK(div_clk, 5'h00)
        `CHK({fb_set, pre_set}, {DIV_RESET, DIV_RESET})
        `CHK({pump_set, filt_set}, {LOOP_RESET, LOOP_RESET})
        run('0, 0);
        run('1, 1);
        for (int t = 2; t < 7; t++)
        begin
            raw = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
            img = raw[CHAIN_BITS-1:0];
            for (int i = 0; i < NUM_OUT; i++)
                img[i * DIV_BITS +: DIV_BITS] = rand_div();
            if (t == 3)
                img[CHAIN_BITS-1:FB_BASE] = prev_img[CHAIN_BITS-1:FB_BASE]; // outputs only
            run(img, t);
        end
        summarize();
    end
endmodule : pll_scan_chain_reconfig_bench
